// ==== urpd_regs.vh ====
// register map constants for the uart register page decoder
// assumes inclusion by the decoder module only
`ifndef URPD_REGS_VH
`define URPD_REGS_VH
`define URPD_SLOT_DATA      3'h0
`define URPD_SLOT_IEN       3'h1
`define URPD_SLOT_ISTAT     3'h2
`define URPD_SLOT_LCTRL     3'h3
`define URPD_SLOT_MCTRL     3'h4
`define URPD_SLOT_LSTAT     3'h5
`define URPD_SLOT_MSTAT     3'h6
`define URPD_SLOT_SCRATCH   3'h7
`define URPD_PAGE_KEY       8'hBF
`define URPD_LINE_DIV_BIT        7
`define URPD_ENH_FUNC_ENH_BIT    4
`define URPD_ENABLE_ENH_MASK     8'hF0
`define URPD_INT_STATUS_ENH_MASK 8'h30
`define URPD_FIFO_CTL_ENH_MASK   8'h30
`define URPD_MODEM_CTL_ENH_MASK  8'hE0
`define URPD_MODEM_STS_ENH_MASK  8'hF0
`define URPD_EXTRA_USED_MASK     8'h3F
`define URPD_RST_BYTE            8'h00
`define URPD_RST_INT_SOURCE      6'h01
`endif

// ==== urpd_decoder.v ====
// register page decoder and register bank for a uart with fifos
// assumes a synchronous host bus: one-cycle rd/wr strobes on clk, status
// inputs come from uart logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "urpd_regs.vh"
// What this block does
// - three address lines pick one of eight register slots per access.
// - enhanced page reachable only when line control equals 0xBF exactly.
// - slot 0 divisor bit clear: read receive holding, write transmit holding.
// - slot 0 divisor set, not 0xBF: divisor low byte.
// - slot 1 divisor set, not 0xBF: divisor high byte.
// - divisor mode, divisor zero: slot 0 reads revision code.
// - divisor mode, divisor zero: slot 1 reads identification code.
// - interrupt enable at slot 1 holds eight listed enable bits.
// - slot 2 reads interrupt status with fifo flags; writes fifo control.
// - write-only fifo control holds enable, resets, dma, triggers.
// - line control at slot 3 readable and writable on every page.
// - modem control at slot 4 holds eight listed control bits.
// - read-only line status at slot 5 reports eight receive/transmit flags.
// - slot 5 write, enhanced clear, loads extra feature register.
// - read-only modem status reports change flags and input levels.
// - slot 6 write, enhanced set, loads infrared pulse width.
// - slot 7 is a plain scratch register without side effects.
// - enhanced function register at slot 2 on 0xBF page.
// - 0xBF page slots 4 to 7 hold flow control characters.
// - enhanced-capable bits act only with enhanced enable, else read zero.
// - enhanced enable unlocks listed upper bits and the infrared pulse width register.
module urpd_decoder #(
    parameter [7:0] REVISION_CODE = 8'h01, // arbitrary value
    parameter [7:0] IDENT_CODE    = 8'h5A  // arbitrary value
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [2:0] addr,
    input  wire       rd,
    input  wire       wr,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata,
    input  wire [7:0] rx_char,
    input  wire [5:0] int_source,
    input  wire [7:0] line_flags,
    input  wire [7:0] modem_flags,
    output reg  [7:0] transmit_holding,
    output reg        tx_load,
    output reg        rx_read,
    output reg        modem_status_read,
    output reg        int_status_read,
    output reg  [7:0] divisor_low,
    output reg  [7:0] divisor_high,
    output reg  [7:0] interrupt_enable,
    output reg  [7:0] fifo_control,
    output reg        rx_fifo_reset,
    output reg        tx_fifo_reset,
    output reg  [7:0] line_control,
    output reg  [7:0] modem_control,
    output reg  [7:0] extra_feature,
    output reg  [7:0] infrared_pulse_width,
    output reg  [7:0] scratch,
    output reg  [7:0] enhanced_function,
    output reg  [7:0] resume_char_one,
    output reg  [7:0] resume_char_two,
    output reg  [7:0] pause_char_one,
    output reg  [7:0] pause_char_two
);

    // stored values; enable and modem control before enhanced gating, fifo control after; outputs carry the gated view
    reg  [7:0] enable_stored;
    reg  [7:0] modem_ctl_stored;
    reg  [7:0] fifo_ctl_stored;
    reg  [7:0] next_rdata;

    wire key_page  = (line_control == `URPD_PAGE_KEY);
    wire div_mode  = line_control[`URPD_LINE_DIV_BIT] & ~key_page;
    wire base_page = ~line_control[`URPD_LINE_DIV_BIT];
    wire enh       = enhanced_function[`URPD_ENH_FUNC_ENH_BIT];
    wire div_zero  = (divisor_low == `URPD_RST_BYTE) && (divisor_high == `URPD_RST_BYTE);
    wire [7:0] enable_gate    = enh ? 8'hFF : ~`URPD_ENABLE_ENH_MASK;
    wire [7:0] modem_ctl_gate = enh ? 8'hFF : ~`URPD_MODEM_CTL_ENH_MASK;
    wire [7:0] fifo_ctl_gate  = enh ? 8'hFF : ~`URPD_FIFO_CTL_ENH_MASK;
    wire [7:0] int_sts_gate   = enh ? 8'hFF : ~`URPD_INT_STATUS_ENH_MASK;
    wire [7:0] modem_sts_gate = enh ? 8'hFF : ~`URPD_MODEM_STS_ENH_MASK;
    // fifo flags report fifo enable in both top bits
    wire [7:0] int_status_view = {fifo_ctl_stored[0], fifo_ctl_stored[0], int_source}
                                 & int_sts_gate;

    always @* begin
        // unmapped slots on the current page read as zero
        next_rdata = `URPD_RST_BYTE;
        case (addr)
            `URPD_SLOT_DATA: begin
                if (div_mode)
                    next_rdata = div_zero ? REVISION_CODE : divisor_low;
                else if (base_page)
                    next_rdata = rx_char;
            end
            `URPD_SLOT_IEN: begin
                if (div_mode)
                    next_rdata = div_zero ? IDENT_CODE : divisor_high;
                else if (base_page)
                    next_rdata = enable_stored & enable_gate;
            end
            `URPD_SLOT_ISTAT: begin
                if (key_page)
                    next_rdata = enhanced_function;
                else if (base_page)
                    next_rdata = int_status_view;
            end
            `URPD_SLOT_LCTRL: next_rdata = line_control;
            `URPD_SLOT_MCTRL: begin
                if (key_page)
                    next_rdata = resume_char_one;
                else if (base_page)
                    next_rdata = modem_ctl_stored & modem_ctl_gate;
            end
            `URPD_SLOT_LSTAT: begin
                if (key_page)
                    next_rdata = resume_char_two;
                else if (base_page)
                    next_rdata = line_flags;
            end
            `URPD_SLOT_MSTAT: begin
                if (key_page)
                    next_rdata = pause_char_one;
                else if (base_page)
                    next_rdata = modem_flags & modem_sts_gate;
            end
            `URPD_SLOT_SCRATCH: begin
                if (key_page)
                    next_rdata = pause_char_two;
                else if (base_page)
                    next_rdata = scratch;
            end
            default: next_rdata = `URPD_RST_BYTE;
        endcase
    end

    // read strobes tell the uart which status was consumed
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata             <= `URPD_RST_BYTE;
            rx_read           <= 1'h0;
            int_status_read   <= 1'h0;
            modem_status_read <= 1'h0;
        end else begin
            // rdata holds between reads so a slow host can sample it late
            if (rd)
                rdata <= next_rdata;
            rx_read           <= rd && base_page && (addr == `URPD_SLOT_DATA);
            int_status_read   <= rd && base_page && (addr == `URPD_SLOT_ISTAT);
            modem_status_read <= rd && base_page && (addr == `URPD_SLOT_MSTAT);
        end
    end

    // write decode; read-only slots have no enable, so writes fall away
    wire wr_base      = wr && base_page;
    wire wr_div       = wr && div_mode;
    wire wr_key       = wr && key_page;
    wire we_tx_hold   = wr_base && (addr == `URPD_SLOT_DATA);
    wire we_div_low   = wr_div && (addr == `URPD_SLOT_DATA);
    wire we_div_high  = wr_div && (addr == `URPD_SLOT_IEN);
    wire we_int_en    = wr_base && (addr == `URPD_SLOT_IEN);
    wire we_fifo_ctl  = wr_base && (addr == `URPD_SLOT_ISTAT);
    wire we_enh_func  = wr_key && (addr == `URPD_SLOT_ISTAT);
    wire we_line_ctl  = wr && (addr == `URPD_SLOT_LCTRL);
    wire we_modem_ctl = wr_base && (addr == `URPD_SLOT_MCTRL);
    wire we_extra     = wr_base && (addr == `URPD_SLOT_LSTAT) && !enh;
    wire we_pulse_w   = wr_base && (addr == `URPD_SLOT_MSTAT) && enh;
    wire we_scratch   = wr_base && (addr == `URPD_SLOT_SCRATCH);
    wire we_resume1   = wr_key && (addr == `URPD_SLOT_MCTRL);
    wire we_resume2   = wr_key && (addr == `URPD_SLOT_LSTAT);
    wire we_pause1    = wr_key && (addr == `URPD_SLOT_MSTAT);
    wire we_pause2    = wr_key && (addr == `URPD_SLOT_SCRATCH);

    // strobes come from the same enables as the stores, so they cannot disagree
    // one-cycle strobes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_load       <= 1'h0;
            rx_fifo_reset <= 1'h0;
            tx_fifo_reset <= 1'h0;
        end else begin
            tx_load       <= we_tx_hold;
            rx_fifo_reset <= we_fifo_ctl && wdata[1];
            tx_fifo_reset <= we_fifo_ctl && wdata[2];
        end
    end

    // a read of slot 0 never touches this register
    // transmit holding
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_holding <= `URPD_RST_BYTE;
        end else if (we_tx_hold) begin
            transmit_holding <= wdata;
        end
    end

    // a zero divisor doubles as the key that shows the two device codes
    // divisor low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divisor_low <= `URPD_RST_BYTE;
        end else if (we_div_low) begin
            divisor_low <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divisor_high <= `URPD_RST_BYTE;
        end else if (we_div_high) begin
            divisor_high <= wdata;
        end
    end

    // stored whole; gating on the way out hides locked bits without losing them
    // enable bits
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_stored <= `URPD_RST_BYTE;
        end else if (we_int_en) begin
            enable_stored <= wdata;
        end
    end

    // trigger bits stored as zero while locked; a later unlock shows no stale value
    // fifo control
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_ctl_stored <= `URPD_RST_BYTE;
        end else if (we_fifo_ctl) begin
            fifo_ctl_stored <= wdata & fifo_ctl_gate;
        end
    end

    // writable on every page, so software can always leave the enhanced page
    // line control
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_control <= `URPD_RST_BYTE;
        end else if (we_line_ctl) begin
            line_control <= wdata;
        end
    end

    // stored whole like the enable bits; consumers see the gated view
    // modem control
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_ctl_stored <= `URPD_RST_BYTE;
        end else if (we_modem_ctl) begin
            modem_ctl_stored <= wdata;
        end
    end

    // reserved top bits are dropped so nothing downstream ever sees them
    // extra feature
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extra_feature <= `URPD_RST_BYTE;
        end else if (we_extra) begin
            extra_feature <= wdata & `URPD_EXTRA_USED_MASK;
        end
    end

    // shares its slot with modem status, so only the enhanced view reaches it
    // pulse width
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            infrared_pulse_width <= `URPD_RST_BYTE;
        end else if (we_pulse_w) begin
            infrared_pulse_width <= wdata;
        end
    end

    // no strobe or side effect leaves this register
    // scratch store
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch <= `URPD_RST_BYTE;
        end else if (we_scratch) begin
            scratch <= wdata;
        end
    end

    // bit 4 unlocks the gated fields from the next edge on
    // enhanced function
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enhanced_function <= `URPD_RST_BYTE;
        end else if (we_enh_func) begin
            enhanced_function <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_char_one <= `URPD_RST_BYTE;
        end else if (we_resume1) begin
            resume_char_one <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_char_two <= `URPD_RST_BYTE;
        end else if (we_resume2) begin
            resume_char_two <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_char_one <= `URPD_RST_BYTE;
        end else if (we_pause1) begin
            pause_char_one <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_char_two <= `URPD_RST_BYTE;
        end else if (we_pause2) begin
            pause_char_two <= wdata;
        end
    end

    // one cycle of lag is traded for plain flip-flop outputs
    // gated views
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enable <= `URPD_RST_BYTE;
            modem_control    <= `URPD_RST_BYTE;
            fifo_control     <= `URPD_RST_BYTE;
        end else begin
            interrupt_enable <= enable_stored & enable_gate;
            modem_control    <= modem_ctl_stored & modem_ctl_gate;
            fifo_control     <= fifo_ctl_stored & fifo_ctl_gate;
        end
    end

endmodule
`default_nettype wire

// ==== urpd_monitor.sv ====
// assertions on the uart register page decoder ports
// bound into every urpd_decoder; one clock domain, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module urpd_monitor (
    input wire       clk,
    input wire       rst_n,
    input wire [2:0] addr,
    input wire       rd,
    input wire       wr,
    input wire [7:0] wdata,
    input wire [7:0] transmit_holding,
    input wire       tx_load,
    input wire       rx_read,
    input wire       int_status_read,
    input wire       modem_status_read,
    input wire       rx_fifo_reset,
    input wire       tx_fifo_reset,
    input wire [7:0] divisor_low,
    input wire [7:0] divisor_high,
    input wire [7:0] interrupt_enable,
    input wire [7:0] fifo_control,
    input wire [7:0] line_control,
    input wire [7:0] modem_control,
    input wire [7:0] infrared_pulse_width,
    input wire [7:0] enhanced_function,
    input wire [7:0] resume_char_one
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire base = !line_control[7];
    wire divp = line_control[7] && line_control != 8'hBF;
    wire enhp = line_control == 8'hBF;
    wire enh  = enhanced_function[4];
    AST_TX_LOAD: assert property (wr && addr == 3'h0 && base |=>
        tx_load && transmit_holding == $past(wdata)) else $error("tx load wrong");
    AST_RX_READ: assert property (rd && addr == 3'h0 && base |=> rx_read)
        else $error("rx read pulse missing");
    AST_DIV_LOW: assert property (wr && addr == 3'h0 && divp |=>
        divisor_low == $past(wdata)) else $error("divisor low not loaded");
    AST_DIV_HIGH: assert property (wr && addr == 3'h1 && divp |=>
        divisor_high == $past(wdata)) else $error("divisor high not loaded");
    AST_LCR_ANY_PAGE: assert property (wr && addr == 3'h3 |=>
        line_control == $past(wdata)) else $error("line control not loaded");
    AST_EFR_PAGE: assert property (wr && addr == 3'h2 && enhp |-> ##1
        enhanced_function == $past(wdata)) else $error("enhanced function not loaded");
    AST_RESUME_ONE: assert property (wr && addr == 3'h4 && enhp |=>
        resume_char_one == $past(wdata)) else $error("flow char not loaded");
    AST_UPPER_GATED: assert property (!enh && !$past(enh) |->
        interrupt_enable[7:4] == 4'h0 && modem_control[7:5] == 3'h0
        && fifo_control[5:4] == 2'h0) else $error("locked bits visible");
    AST_PW_REFUSED: assert property (wr && addr == 3'h6 && base && !enh |=>
        $stable(infrared_pulse_width)) else $error("pulse width written while locked");
    AST_INT_STATUS_READ: assert property (rd && addr == 3'h2 && base |=>
        int_status_read) else $error("interrupt status read pulse missing");
    AST_MODEM_STATUS_READ: assert property (rd && addr == 3'h6 && base |=>
        modem_status_read) else $error("modem status read pulse missing");
    AST_FIFO_RESET: assert property (wr && addr == 3'h2 && base |=>
        rx_fifo_reset == $past(wdata[1]) && tx_fifo_reset == $past(wdata[2]))
        else $error("fifo reset pulse wrong");
    AST_FIFO_RESET_QUIET: assert property (!(wr && addr == 3'h2 && base) |=>
        !rx_fifo_reset && !tx_fifo_reset) else $error("fifo reset without write");
    cover property (wr && enhp);
    cover property (rd && addr == 3'h0 && divp && divisor_low == 8'h00);
    cover property (wr && addr == 3'h1 && base && enh);
endmodule
bind urpd_decoder urpd_monitor mon (.clk, .rst_n, .addr, .rd, .wr, .wdata,
    .transmit_holding, .tx_load, .rx_read, .int_status_read, .modem_status_read,
    .rx_fifo_reset, .tx_fifo_reset, .divisor_low, .divisor_high,
    .interrupt_enable, .fifo_control, .line_control, .modem_control,
    .infrared_pulse_width, .enhanced_function, .resume_char_one);
`default_nettype wire

// ==== urpd_host.sv ====
// host processor model on the 8-bit register bus
// strobes are one-cycle pulses launched just after a rising clk edge
`timescale 1ns/100ps
`default_nettype none
module urpd_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [2:0] addr,
    output logic            rd,
    output logic            wr,
    output logic      [7:0] wdata
);
    initial begin
        addr  = 3'h0;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = 8'h00;
    end
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // released data bus shows no stale value
        wdata <= ~d;
        @(posedge clk);
        #1;
    endtask
    task automatic get(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ==== urpd_tb.sv ====
// self-checking bench for the uart register page decoder
// host model drives the bus; status inputs are steady known patterns
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] REV = 8'h21; // arbitrary value
    localparam logic [7:0] IDC = 8'h4E; // arbitrary value
    logic       clk, rst_n, rd, wr, tx_load, rx_read, modem_status_read, int_status_read;
    logic       rx_fifo_reset, tx_fifo_reset;
    logic [2:0] addr;
    logic [5:0] int_source;
    logic [7:0] wdata, rdata, rx_char, line_flags, modem_flags, transmit_holding, v;
    logic [7:0] divisor_low, divisor_high, interrupt_enable, fifo_control, line_control;
    logic [7:0] modem_control, extra_feature, infrared_pulse_width, scratch;
    logic [7:0] enhanced_function, resume_char_one, resume_char_two;
    logic [7:0] pause_char_one, pause_char_two;
    int         mismatches = 0;
    int         total_checks = 0;
    urpd_decoder #(.REVISION_CODE(REV), .IDENT_CODE(IDC)) uut (.clk, .rst_n, .addr,
        .rd, .wr, .wdata, .rdata, .rx_char, .int_source, .line_flags, .modem_flags,
        .transmit_holding, .tx_load, .rx_read, .modem_status_read, .int_status_read,
        .divisor_low,
        .divisor_high, .interrupt_enable, .fifo_control, .rx_fifo_reset, .tx_fifo_reset,
        .line_control, .modem_control, .extra_feature, .infrared_pulse_width, .scratch,
        .enhanced_function, .resume_char_one, .resume_char_two, .pause_char_one,
        .pause_char_two);
    urpd_host host (.clk, .rdata, .addr, .rd, .wr, .wdata);
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_base;
        host.put(3'h7, 8'hA5);
        host.get(3'h7, v);
        chk("scratch", v, 8'hA5);
        host.put(3'h0, 8'h3C);
        chk("transmit_holding", transmit_holding, 8'h3C);
        host.get(3'h0, v);
        chk("receive_holding", v, 8'hC3);
        host.get(3'h5, v);
        chk("line_status", v, 8'h61);
        host.get(3'h6, v);
        chk("modem_status", v, 8'h04);
        host.put(3'h2, 8'hF7);
        host.get(3'h2, v);
        chk("interrupt_status", v, 8'hCC);
        chk("fifo_control", fifo_control, 8'hC7);
        host.put(3'h1, 8'hFF);
        host.get(3'h1, v);
        chk("interrupt_enable", v, 8'h0F);
        host.put(3'h5, 8'hFF);
        chk("extra_feature", extra_feature, 8'h3F);
        host.put(3'h6, 8'h55);
        chk("infrared_pulse_width", infrared_pulse_width, 8'h00);
    endtask
    task automatic t_div;
        host.put(3'h3, 8'h80);
        host.get(3'h0, v);
        chk("revision_code", v, REV);
        host.get(3'h1, v);
        chk("identification_code", v, IDC);
        host.put(3'h0, 8'h34);
        host.put(3'h1, 8'h12);
        host.get(3'h0, v);
        chk("divisor_low", v, 8'h34);
        host.get(3'h1, v);
        chk("divisor_high", v, 8'h12);
        chk("transmit_holding", transmit_holding, 8'h3C);
    endtask
    task automatic t_enh;
        host.put(3'h3, 8'hBF);
        host.put(3'h2, 8'h1A);
        host.put(3'h1, 8'hEE);
        chk("divisor_high", divisor_high, 8'h12);
        for (int i = 4; i < 8; i++) begin
            host.put(3'(i), 8'h10 + 8'(i));
        end
        for (int i = 4; i < 8; i++) begin
            host.get(3'(i), v);
            chk("flow_char", v, 8'h10 + 8'(i));
        end
        host.get(3'h2, v);
        chk("enhanced_function", v, 8'h1A);
        host.get(3'h3, v);
        chk("line_control", v, 8'hBF);
    endtask
    task automatic t_gate;
        host.put(3'h3, 8'h03);
        host.put(3'h1, 8'hFF);
        host.get(3'h1, v);
        chk("interrupt_enable", v, 8'hFF);
        host.put(3'h4, 8'hE5);
        chk("modem_control", modem_control, 8'hE5);
        host.get(3'h2, v);
        chk("interrupt_status", v, 8'hFC);
        host.get(3'h6, v);
        chk("modem_status", v, 8'hB4);
        host.put(3'h6, 8'h77);
        chk("infrared_pulse_width", infrared_pulse_width, 8'h77);
        host.put(3'h5, 8'h01);
        chk("extra_feature", extra_feature, 8'h3F);
    endtask
    initial begin
        rst_n       = 1'b0;
        rx_char     = 8'hC3;
        int_source  = 6'h3C;
        line_flags  = 8'h61;
        modem_flags = 8'hB4;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("line_control", line_control, 8'h00);
        t_base();
        t_div();
        t_enh();
        t_gate();
        wrap_up();
    end
    // whole run needs about 125 cycles
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
